// >>> rtl/tlic_top.sv
`default_nettype none
// How it works
// - twelve request slots resolved over three priority levels
// - supply monitor alone sits on top level, preempts everything
// - high configurable level preempts a low-level service routine
// - simultaneous requests of different levels: higher level vectored first
// - no vectoring to a level already in service until return
// - same-level simultaneous requests chosen by fixed polling order
// - shutdown blocks interrupts; wake-up events reported separately
// - reset values 0x00, 0x00, 0xa0, 0x10 for the four registers
// - enable, priority, watchdog bit-addressable; enable-priority-2 byte only
// - enable bit 7 gates every source globally
// - enable bits 5..0: timer2, uart, timer1, ext1, timer0, ext0
// - enable bits reachable at bit addresses 0xa8 to 0xaf
// - priority bits: 1 high, 0 low, one per source except supply monitor and wdt
// - priority bits reachable at bit addresses 0xb8 to 0xbf
// - enable-priority-2 holds rtc/spi priority and four more enables
// - polling order supply, rtc, metering, wdt, ext0 ... uart, timer2
// - vectors from 0x0003 every eight bytes to 0x005b
module tlic_top #(
  parameter int WAKE_W = 4
) (
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset, active low
  input wire tlic_pkg::tlic_sfr_req_t i_sfr, // byte register access
  input wire tlic_pkg::tlic_bit_req_t i_bit, // bit register access
  output logic o_sfr_sel, // byte address is ours
  output logic [7:0] o_sfr_rdata_ff, // byte read data
  output logic o_bit_sel, // bit address is ours
  output logic o_bit_rdata_ff, // bit read data
  input wire logic [tlic_pkg::NUM_SRC-1:0] i_irq_req, // source requests
  input wire logic i_wdt_timeout, // watchdog timeout event
  input wire logic i_core_shutdown, // core is shut down
  input wire logic [WAKE_W-1:0] i_wake_evt, // wake-up events
  output logic o_wake_ff, // wake request to power control
  output logic o_int_req_ff, // interrupt request to core
  output logic [15:0] o_int_vector_ff, // vector address
  output logic [tlic_pkg::SRC_W-1:0] o_int_src_ff, // source index
  output logic [tlic_pkg::LVL_W-1:0] o_int_lvl_ff, // level of request
  input wire logic i_int_ack, // core takes the vector
  input wire logic i_reti, // return from service routine
  output logic [tlic_pkg::LEVELS-1:0] o_active_lvl // levels in service
);
  localparam int NS = tlic_pkg::NUM_SRC;
  localparam int NL = tlic_pkg::LEVELS;
  localparam int LW = tlic_pkg::LVL_W;
  localparam int SW = tlic_pkg::SRC_W;

  tlic_pkg::tlic_regs_t regs_ff;
  tlic_pkg::tlic_regs_t nxt_regs;
  tlic_pkg::tlic_regs_t rst_regs;
  logic [LW-1:0] lvl_of [NS];
  logic [NS-1:0] src_en;
  logic [NS-1:0] masked_req;
  logic [NS-1:0] lvl_req [NL];
  logic [NL-1:0] lvl_valid;
  logic [SW-1:0] lvl_idx [NL];
  logic [NL-1:0] lvl_allowed;
  logic [NL-1:0] active;
  logic [NL-1:0] nxt_active;
  logic pick_valid;
  logic [SW-1:0] pick_idx;
  logic [LW-1:0] pick_lvl;
  logic take;
  logic holdoff_ff;
  logic irq_reg_access;
  logic holdoff_now;
  logic nxt_req;
  logic hit_ie;
  logic hit_ip;
  logic hit_irq_enable_priority2_reg;
  logic hit_watchdog_control_reg;
  logic bhit_ie;
  logic bhit_ip;
  logic bhit_watchdog_control_reg;
  logic [7:0] byte_rd;
  logic bit_rd;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic bit_in(input logic [7:0] a,
                                  input logic [7:0] base);
    bit_in = (a[7:3] == base[7:3]);
  endfunction

  function automatic logic [LW-1:0] src_level(
      input tlic_pkg::tlic_regs_t r, input int s);
    logic [LW-1:0] l;
    l = tlic_pkg::LVL_LOW;
    case (s)
      tlic_pkg::SRC_EXT0: l = {1'b0, r.ip[tlic_pkg::EXT_PIN0_IRQ_PRIORITY]};
      tlic_pkg::SRC_TIMER0: l = {1'b0, r.ip[tlic_pkg::TIMER0_IRQ_PRIORITY]};
      tlic_pkg::SRC_EXT1: l = {1'b0, r.ip[tlic_pkg::EXT_PIN1_IRQ_PRIORITY]};
      tlic_pkg::SRC_TIMER1: l = {1'b0, r.ip[tlic_pkg::TIMER1_IRQ_PRIORITY]};
      tlic_pkg::SRC_UART:
        l = {1'b0, r.ip[tlic_pkg::SERIAL_PORT_IRQ_PRIORITY]};
      tlic_pkg::SRC_TIMER2: l = {1'b0, r.ip[tlic_pkg::TIMER2_IRQ_PRIORITY]};
      tlic_pkg::SRC_SPI:
        l = {1'b0, r.irq_enable_priority2_reg[tlic_pkg::SERIAL_PERIPH_IRQ_PRIORITY]};
      tlic_pkg::SRC_SUPPLY: l = tlic_pkg::LVL_TOP;
      tlic_pkg::SRC_ADE:
        l = {1'b0, r.ip[tlic_pkg::METERING_IRQ_PRIORITY]};
      tlic_pkg::SRC_RTC: l = {1'b0, r.irq_enable_priority2_reg[tlic_pkg::RTC_IRQ_PRIORITY]};
      default: l = tlic_pkg::LVL_LOW;
    endcase
    src_level = l;
  endfunction

  function automatic logic src_enable(input tlic_pkg::tlic_regs_t r,
                                      input int s);
    logic e;
    e = 1'b0;
    case (s)
      tlic_pkg::SRC_EXT0: e = r.ie[tlic_pkg::EXT_PIN0_IRQ_ENABLE];
      tlic_pkg::SRC_TIMER0: e = r.ie[tlic_pkg::TIMER0_IRQ_ENABLE];
      tlic_pkg::SRC_EXT1: e = r.ie[tlic_pkg::EXT_PIN1_IRQ_ENABLE];
      tlic_pkg::SRC_TIMER1: e = r.ie[tlic_pkg::TIMER1_IRQ_ENABLE];
      tlic_pkg::SRC_UART: e = r.ie[tlic_pkg::SERIAL_PORT_IRQ_ENABLE];
      tlic_pkg::SRC_TIMER2: e = r.ie[tlic_pkg::TIMER2_IRQ_ENABLE];
      tlic_pkg::SRC_SPI: e = r.irq_enable_priority2_reg[tlic_pkg::SERIAL_PERIPH_IRQ_ENABLE];
      tlic_pkg::SRC_SUPPLY: e = r.irq_enable_priority2_reg[tlic_pkg::SUPPLY_MONITOR_IRQ_ENABLE];
      tlic_pkg::SRC_ADE: e = r.irq_enable_priority2_reg[tlic_pkg::METERING_IRQ_ENABLE];
      tlic_pkg::SRC_RTC: e = r.irq_enable_priority2_reg[tlic_pkg::RTC_INTERVAL_IRQ_ENABLE];
      tlic_pkg::SRC_WDT: e = r.watchdog_control_reg[tlic_pkg::WDT_IRQ_ENABLE];
      default: e = 1'b0;
    endcase
    src_enable = e;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign rst_regs = '{ie: tlic_pkg::RST_IRQ_EN,
                      irq_enable_priority2_reg: tlic_pkg::RST_IRQ_EN_PRIO2,
                      ip: tlic_pkg::RST_IRQ_PRIO,
                      watchdog_control_reg: tlic_pkg::RST_WDT_CTRL};
  assign hit_ie = (i_sfr.addr == tlic_pkg::ADDR_IRQ_EN);
  assign hit_ip = (i_sfr.addr == tlic_pkg::ADDR_IRQ_PRIO);
  assign hit_irq_enable_priority2_reg = (i_sfr.addr == tlic_pkg::ADDR_IRQ_EN_PRIO2);
  assign hit_watchdog_control_reg = (i_sfr.addr == tlic_pkg::ADDR_WDT_CTRL);
  assign bhit_ie = bit_in(i_bit.addr, tlic_pkg::ADDR_IRQ_EN);
  assign bhit_ip = bit_in(i_bit.addr, tlic_pkg::ADDR_IRQ_PRIO);
  assign bhit_watchdog_control_reg = bit_in(i_bit.addr, tlic_pkg::ADDR_WDT_CTRL);
  assign o_sfr_sel = hit_ie | hit_ip | hit_irq_enable_priority2_reg | hit_watchdog_control_reg;
  assign o_bit_sel = bhit_ie | bhit_ip | bhit_watchdog_control_reg;

  always_comb begin
    nxt_regs = regs_ff;
    if (i_sfr.wr && hit_ie) begin
      nxt_regs.ie = i_sfr.wdata;
    end
    if (i_sfr.wr && hit_ip) begin
      nxt_regs.ip = i_sfr.wdata;
    end
    if (i_sfr.wr && hit_irq_enable_priority2_reg) begin
      nxt_regs.irq_enable_priority2_reg = i_sfr.wdata;
    end
    if (i_sfr.wr && hit_watchdog_control_reg) begin
      nxt_regs.watchdog_control_reg = i_sfr.wdata;
    end
    if (i_bit.wr && bhit_ie) begin
      nxt_regs.ie[i_bit.addr[2:0]] = i_bit.wdata;
    end
    if (i_bit.wr && bhit_ip) begin
      nxt_regs.ip[i_bit.addr[2:0]] = i_bit.wdata;
    end
    if (i_bit.wr && bhit_watchdog_control_reg) begin
      nxt_regs.watchdog_control_reg[i_bit.addr[2:0]] = i_bit.wdata;
    end
    // hardware set wins over a software clear
    if (i_wdt_timeout) begin
      nxt_regs.watchdog_control_reg[tlic_pkg::WDT_TIMEOUT_FLAG] = 1'b1;
    end
  end

  assign byte_rd = hit_ie ? regs_ff.ie :
                   hit_ip ? regs_ff.ip :
                   hit_irq_enable_priority2_reg ? regs_ff.irq_enable_priority2_reg :
                   hit_watchdog_control_reg ? regs_ff.watchdog_control_reg : 8'h00;
  assign bit_rd = bhit_ie ? regs_ff.ie[i_bit.addr[2:0]] :
                  bhit_ip ? regs_ff.ip[i_bit.addr[2:0]] :
                  bhit_watchdog_control_reg ? regs_ff.watchdog_control_reg[i_bit.addr[2:0]] : 1'b0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      regs_ff <= '{ie: tlic_pkg::RST_IRQ_EN,
                   irq_enable_priority2_reg: tlic_pkg::RST_IRQ_EN_PRIO2,
                   ip: tlic_pkg::RST_IRQ_PRIO,
                   watchdog_control_reg: tlic_pkg::RST_WDT_CTRL};
      o_sfr_rdata_ff <= 8'h00;
      o_bit_rdata_ff <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
      o_sfr_rdata_ff <= i_sfr.rd ? byte_rd : 8'h00;
      o_bit_rdata_ff <= i_bit.rd ? bit_rd : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // gating and per-level polling
  // ----------------------------------------------------------------
  genvar gs, gl;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_src
      assign lvl_of[gs] = src_level(regs_ff, gs);
      assign src_en[gs] = src_enable(regs_ff, gs);
    end
  endgenerate

  assign masked_req = i_irq_req & src_en &
                      {NS{regs_ff.ie[tlic_pkg::GLOBAL_IRQ_ENABLE]}};

  generate
    for (gl = 0; gl < NL; gl++) begin : g_lvl
      for (gs = 0; gs < NS; gs++) begin : g_bit
        assign lvl_req[gl][gs] = masked_req[gs] &&
                                 (lvl_of[gs] == LW'(gl));
      end
      tlic_poll_pick #(
        .NUM_SRC(NS),
        .SRC_W(SW)
      ) u_pick (
        .i_req(lvl_req[gl]),
        .o_valid(lvl_valid[gl]),
        .o_idx(lvl_idx[gl])
      );
      // a level may vector only above every level in service
      assign lvl_allowed[gl] = ~|(nxt_active >> gl);
    end
  endgenerate

  // higher levels override lower ones
  always_comb begin
    pick_valid = 1'b0;
    pick_idx = '0;
    pick_lvl = tlic_pkg::LVL_LOW;
    for (int l = 0; l < NL; l++) begin
      if (lvl_valid[l] && lvl_allowed[l]) begin
        pick_valid = 1'b1;
        pick_idx = lvl_idx[l];
        pick_lvl = LW'(l);
      end
    end
  end

  // ----------------------------------------------------------------
  // in-service tracking and request to the core
  // ----------------------------------------------------------------
  assign take = i_int_ack && o_int_req_ff;

  tlic_level_track #(
    .LEVELS(NL),
    .LVL_W(LW)
  ) u_track (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_enter(take),
    .i_enter_lvl(o_int_lvl_ff),
    .i_leave(i_reti),
    .o_active(active),
    .o_nxt_active(nxt_active)
  );

  // one instruction must pass after return or enable/priority access
  assign irq_reg_access = ((i_sfr.wr || i_sfr.rd) && (hit_ie || hit_ip)) ||
                          ((i_bit.wr || i_bit.rd) && (bhit_ie || bhit_ip));
  assign holdoff_now = i_reti || irq_reg_access || holdoff_ff;
  assign nxt_req = pick_valid && !i_core_shutdown && !holdoff_now &&
                   !i_int_ack;
  assign o_active_lvl = active;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      holdoff_ff <= 1'b0;
      o_int_req_ff <= 1'b0;
      o_int_vector_ff <= tlic_pkg::VEC_BASE;
      o_int_src_ff <= '0;
      o_int_lvl_ff <= tlic_pkg::LVL_LOW;
      o_wake_ff <= 1'b0;
    end else begin
      holdoff_ff <= i_reti || irq_reg_access;
      o_int_req_ff <= nxt_req;
      o_int_src_ff <= pick_idx;
      o_int_lvl_ff <= pick_lvl;
      o_int_vector_ff <= tlic_pkg::VEC_BASE +
                         (16'(pick_idx) << tlic_pkg::VEC_SHIFT);
      o_wake_ff <= i_core_shutdown && (|i_wake_evt);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  shutdown_block_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_core_shutdown |=> !o_int_req_ff)
    else $error("request raised while core shut down");

  global_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !regs_ff.ie[tlic_pkg::GLOBAL_IRQ_ENABLE] |=> !o_int_req_ff)
    else $error("request raised with global enable clear");

  reset_values_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> (regs_ff == rst_regs))
    else $error("register reset value wrong");

  level_nest_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_int_req_ff |-> ((active >> o_int_lvl_ff) == '0))
    else $error("request at or below a level in service");

  psm_top_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_int_req_ff && o_int_src_ff == tlic_pkg::SRC_SUPPLY)
      |-> (o_int_lvl_ff == tlic_pkg::LVL_TOP))
    else $error("supply monitor not at top level");

  vector_map_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_int_req_ff |-> (o_int_vector_ff ==
      tlic_pkg::VEC_BASE + {9'h000, o_int_src_ff, 3'h0}))
    else $error("vector address does not match source");

  reti_holdoff_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_reti |=> !o_int_req_ff [*2])
    else $error("vectored right after return");

  ie_bitwrite_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bit.wr && bhit_ie && !i_sfr.wr)
      |=> (regs_ff.ie[$past(i_bit.addr[2:0])] == $past(i_bit.wdata)))
    else $error("enable bit write lost");

  irq_enable_priority2_reg_byteonly_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(i_sfr.wr && hit_irq_enable_priority2_reg) |=> (regs_ff.irq_enable_priority2_reg == $past(regs_ff.irq_enable_priority2_reg)))
    else $error("enable-priority-2 changed without byte write");

  wdt_flag_set_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_wdt_timeout |=> regs_ff.watchdog_control_reg[tlic_pkg::WDT_TIMEOUT_FLAG])
    else $error("watchdog timeout flag not set");
endmodule // tlic_top
`default_nettype wire

// >>> rtl/tlic_pkg.sv
`default_nettype none
package tlic_pkg;
  // ----------------------------------------------------------------
  // sizes and levels
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 12;
  localparam int SRC_W = 4;
  localparam int LEVELS = 3;
  localparam int LVL_W = 2;
  localparam int NUM_POLL = 11;
  localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
  localparam logic [LVL_W-1:0] LVL_HIGH = 2'h1;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h2;

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN = 8'ha8;
  localparam logic [7:0] ADDR_IRQ_EN_PRIO2 = 8'ha9;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'hb8;
  localparam logic [7:0] ADDR_WDT_CTRL = 8'hc0;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_EN_PRIO2 = 8'ha0;
  localparam logic [7:0] RST_IRQ_PRIO = 8'h00;
  localparam logic [7:0] RST_WDT_CTRL = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE = 7;
  localparam int TIMER2_IRQ_ENABLE = 5;
  localparam int SERIAL_PORT_IRQ_ENABLE = 4;
  localparam int TIMER1_IRQ_ENABLE = 3;
  localparam int EXT_PIN1_IRQ_ENABLE = 2;
  localparam int TIMER0_IRQ_ENABLE = 1;
  localparam int EXT_PIN0_IRQ_ENABLE = 0;
  localparam int METERING_IRQ_PRIORITY = 7;
  localparam int TIMER2_IRQ_PRIORITY = 5;
  localparam int SERIAL_PORT_IRQ_PRIORITY = 4;
  localparam int TIMER1_IRQ_PRIORITY = 3;
  localparam int EXT_PIN1_IRQ_PRIORITY = 2;
  localparam int TIMER0_IRQ_PRIORITY = 1;
  localparam int EXT_PIN0_IRQ_PRIORITY = 0;
  localparam int RTC_IRQ_PRIORITY = 6;
  localparam int SERIAL_PERIPH_IRQ_PRIORITY = 4;
  localparam int METERING_IRQ_ENABLE = 3;
  localparam int RTC_INTERVAL_IRQ_ENABLE = 2;
  localparam int SUPPLY_MONITOR_IRQ_ENABLE = 1;
  localparam int SERIAL_PERIPH_IRQ_ENABLE = 0;
  localparam int WDT_TIMEOUT_FLAG = 2;
  localparam int WDT_IRQ_ENABLE = 3;

  // ----------------------------------------------------------------
  // source index = vector slot
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
  localparam logic [SRC_W-1:0] SRC_TIMER0 = 4'h1;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h2;
  localparam logic [SRC_W-1:0] SRC_TIMER1 = 4'h3;
  localparam logic [SRC_W-1:0] SRC_UART = 4'h4;
  localparam logic [SRC_W-1:0] SRC_TIMER2 = 4'h5;
  localparam logic [SRC_W-1:0] SRC_RSVD = 4'h6;
  localparam logic [SRC_W-1:0] SRC_SPI = 4'h7;
  localparam logic [SRC_W-1:0] SRC_SUPPLY = 4'h8;
  localparam logic [SRC_W-1:0] SRC_ADE = 4'h9;
  localparam logic [SRC_W-1:0] SRC_RTC = 4'ha;
  localparam logic [SRC_W-1:0] SRC_WDT = 4'hb;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;

  // first entry is polled first
  localparam logic [SRC_W-1:0] POLL_ORDER [NUM_POLL] = '{
    SRC_SUPPLY, SRC_RTC, SRC_ADE, SRC_WDT, SRC_EXT0, SRC_TIMER0,
    SRC_EXT1, SRC_TIMER1, SRC_SPI, SRC_UART, SRC_TIMER2};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] irq_enable_priority2_reg;
    logic [7:0] ip;
    logic [7:0] watchdog_control_reg;
  } tlic_regs_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic wdata;
  } tlic_bit_req_t;
endpackage
`default_nettype wire

// >>> rtl/tlic_poll_pick.sv
`default_nettype none
module tlic_poll_pick #(
  parameter int NUM_SRC = 12,
  parameter int SRC_W = 4
) (
  input wire logic [NUM_SRC-1:0] i_req, // requests of one level
  output logic o_valid, // any request present at a polled index
  output logic [SRC_W-1:0] o_idx // winning source index
);
  // ----------------------------------------------------------------
  // last assignment is the earliest polled, so it wins
  // ----------------------------------------------------------------
  always_comb begin
    o_valid = 1'b0;
    o_idx = '0;
    for (int k = tlic_pkg::NUM_POLL - 1; k >= 0; k--) begin
      if (i_req[tlic_pkg::POLL_ORDER[k]]) begin
        o_valid = 1'b1;
        o_idx = tlic_pkg::POLL_ORDER[k];
      end
    end
  end
endmodule // tlic_poll_pick
`default_nettype wire

// >>> rtl/tlic_level_track.sv
`default_nettype none
module tlic_level_track #(
  parameter int LEVELS = 3,
  parameter int LVL_W = 2
) (
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_enter, // vector taken
  input wire logic [LVL_W-1:0] i_enter_lvl, // level of taken vector
  input wire logic i_leave, // return from service routine
  output logic [LEVELS-1:0] o_active, // levels in service
  output logic [LEVELS-1:0] o_nxt_active // value after this edge
);
  logic [LEVELS-1:0] active_ff;
  logic [LEVELS-1:0] nxt_active;
  logic [LEVELS-1:0] top_mask;

  // ----------------------------------------------------------------
  // return releases the innermost (highest) level
  // ----------------------------------------------------------------
  always_comb begin
    top_mask = '0;
    for (int l = 0; l < LEVELS; l++) begin
      if (active_ff[l]) begin
        top_mask = '0;
        top_mask[l] = 1'b1;
      end
    end
    nxt_active = active_ff & ~({LEVELS{i_leave}} & top_mask);
    if (i_enter) begin
      nxt_active[i_enter_lvl] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_ff <= '0;
    end else begin
      active_ff <= nxt_active;
    end
  end

  assign o_active = active_ff;
  assign o_nxt_active = nxt_active;
endmodule // tlic_level_track
`default_nettype wire

// >>> sim/tlic_core_model.sv
`default_nettype none
module tlic_core_model (
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_int_req, // request from controller
  input wire logic i_accept, // core may take a vector
  input wire logic i_ret_cmd, // leave service routine
  output logic o_int_ack, // vector taken
  output logic o_reti // return pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle pulses, launched after the falling edge
  always_ff @(negedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_int_ack <= 1'b0;
      o_reti <= 1'b0;
    end else begin
      o_int_ack <= i_int_req & i_accept & ~o_int_ack;
      o_reti <= i_ret_cmd & ~o_reti;
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, shut, acc, ret_cmd, ack, reti, int_req, wake_o;
  logic wdt, sfr_sel, bit_sel, brdata, sel_q, bsel_q;
  tlic_pkg::tlic_sfr_req_t sfr;
  tlic_pkg::tlic_bit_req_t bitr;
  logic [11:0] irq;
  logic [3:0] wake, src;
  logic [7:0] rdata;
  logic [15:0] vec;
  logic [1:0] lvl;
  logic [2:0] active;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  tlic_top dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_sfr(sfr), .i_bit(bitr),
    .o_sfr_sel(sfr_sel), .o_sfr_rdata_ff(rdata), .o_bit_sel(bit_sel),
    .o_bit_rdata_ff(brdata), .i_irq_req(irq), .i_wdt_timeout(wdt),
    .i_core_shutdown(shut), .i_wake_evt(wake), .o_wake_ff(wake_o),
    .o_int_req_ff(int_req), .o_int_vector_ff(vec), .o_int_src_ff(src),
    .o_int_lvl_ff(lvl), .i_int_ack(ack), .i_reti(reti),
    .o_active_lvl(active)
  );
  tlic_core_model core (
    .i_clk(clk), .i_reset_n(rst_n), .i_int_req(int_req),
    .i_accept(acc), .i_ret_cmd(ret_cmd), .o_int_ack(ack), .o_reti(reti)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) sfr = '{1'b1, 1'b0, a, d};
    @(negedge clk) sfr = '0;
  endtask
  task automatic bw(input logic [7:0] a, input logic d);
    @(negedge clk) bitr = '{1'b1, 1'b0, a, d};
    @(negedge clk) bitr = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk) sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) sel_q = sfr_sel;
    sfr = '0;
  endtask
  task automatic brd(input logic [7:0] a);
    @(negedge clk) bitr = '{1'b0, 1'b1, a, 1'b0};
    @(negedge clk) bsel_q = bit_sel;
    bitr = '0;
  endtask
  task automatic wirq(input logic [3:0] s, input logic [1:0] l);
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK(vec, 16'h0003 + {9'h000, s, 3'h0})
    `CHK(src, s)
    `CHK(lvl, l)
    acc <= 1'b1;
    @(negedge clk) acc <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK(int_req, 1'b0)
    end
  endtask
  task automatic ret();
    @(negedge clk) ret_cmd <= 1'b1;
    @(negedge clk) ret_cmd <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(8'ha8);
    `CHK(rdata, 8'h00)
    `CHK(sel_q, 1'b1)
    rd(8'ha9);
    `CHK(rdata, 8'ha0)
    rd(8'hb8);
    `CHK(rdata, 8'h00)
    rd(8'hc0);
    `CHK(rdata, 8'h10)
    bw(8'ha9, 1'b1);
    rd(8'ha8);
    `CHK(rdata, 8'h02)
    rd(8'ha9);
    `CHK(rdata, 8'ha0)
    rd(8'h55);
    `CHK(rdata, 8'h00)
    `CHK(sel_q, 1'b0)
  endtask
  task automatic t_wdt();
    brd(8'hc2);
    `CHK(brdata, 1'b0)
    `CHK(bsel_q, 1'b1)
    @(negedge clk) wdt = 1'b1;
    @(negedge clk) wdt = 1'b0;
    brd(8'hc2);
    `CHK(brdata, 1'b1)
    bw(8'hc3, 1'b1);
    brd(8'hc3);
    `CHK(brdata, 1'b1)
    wr(8'ha9, 8'hb1);
    @(negedge clk) irq = 12'h880;
    wirq(4'h7, 2'h1);
    @(negedge clk) irq = 12'h800;
    quiet(4);
    ret();
    wirq(4'hb, 2'h0);
    @(negedge clk) irq = 12'h000;
    ret();
  endtask
  task automatic t_preempt();
    wr(8'ha8, 8'h83);
    bw(8'hb9, 1'b1);
    wr(8'ha9, 8'ha2);
    @(negedge clk) irq = 12'h001;
    wirq(4'h0, 2'h0);
    `CHK(active, 3'b001)
    quiet(5);
    @(negedge clk) irq = 12'h003;
    wirq(4'h1, 2'h1);
    `CHK(active, 3'b011)
    @(negedge clk) irq = 12'h103;
    wirq(4'h8, 2'h2);
    `CHK(active, 3'b111)
    @(negedge clk) irq = 12'h000;
    ret();
    `CHK(active, 3'b011)
    ret();
    `CHK(active, 3'b001)
    ret();
    `CHK(active, 3'b000)
  endtask
  task automatic t_poll();
    wr(8'hb8, 8'h08);
    wr(8'ha8, 8'h8f);
    wr(8'ha9, 8'ha0);
    @(negedge clk) irq = 12'h00e;
    wirq(4'h3, 2'h1);
    @(negedge clk) irq = 12'h006;
    ret();
    wirq(4'h1, 2'h0);
    @(negedge clk) irq = 12'h000;
    ret();
    wr(8'ha9, 8'ha8);
    @(negedge clk) irq = 12'h201;
    wirq(4'h9, 2'h0);
    @(negedge clk) irq = 12'h000;
    ret();
  endtask
  task automatic t_gate();
    bw(8'haf, 1'b0);
    @(negedge clk) irq = 12'h001;
    quiet(6);
    bw(8'haf, 1'b1);
    wirq(4'h0, 2'h0);
    @(negedge clk) irq = 12'h000;
    ret();
    @(negedge clk);
    shut = 1'b1;
    irq = 12'h001;
    wake = 4'h1;
    quiet(6);
    `CHK(wake_o, 1'b1)
    @(negedge clk);
    shut = 1'b0;
    irq = 12'h000;
    wake = 4'h0;
  endtask

  initial begin
    rst_n = 1'b0;
    sfr = '0;
    bitr = '0;
    irq = '0;
    shut = 1'b0;
    wake = '0;
    acc = 1'b0;
    ret_cmd = 1'b0;
    wdt = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    t_regs();
    t_preempt();
    t_poll();
    t_gate();
    t_wdt();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
